// ==== design/sqsh_params.svh ====
// Constants for the snoop queue and synchronization handshakes
`ifndef SQSH_PARAMS_SVH
`define SQSH_PARAMS_SVH
`define SQSH_QDEPTH 4
`define SQSH_ID_W 4
`define SQSH_ADDR_W 27
`define SQSH_RESP_W 5
`define SQSH_CMD_W 2
`define SQSH_RDY_WINDOW 2
`define SQSH_RDY_FREE_PEND 2
`define SQSH_RDY_FREE_IDLE 3
`define SQSH_RESP_HI_POS 2
`define SQSH_RESP_NULL 3'h0
`define SQSH_RESP_PERR 3'h2
`define SQSH_RESP_HIT 1'h1
`define SQSH_RESP_SYNC 5'h0c
`define SQSH_CC_NONE 2'h0
`define SQSH_ORD_SYNC_MAX 2'h1
`define SQSH_ORD_NO_SYNC 2'h2
`endif

// ==== design/sqsh_pkg.sv ====
// Types for the snoop queue and synchronization handshakes
package sqsh_pkg;
  typedef enum logic [1:0] {
    sqsh_cmd_null = 2'b00,
    sqsh_invalidate_cmd = 2'b01,
    sqsh_cmd_sync = 2'b10,
    sqsh_cmd_rsvd = 2'b11
  } sqsh_cmd_t;
  typedef enum logic [1:0] {
    sqsh_s_idle = 2'b00,
    sqsh_s_look = 2'b01,
    sqsh_s_resp = 2'b10
  } sqsh_snp_state_t;
  typedef enum logic [1:0] {
    sqsh_b_idle = 2'b00,
    sqsh_b_drain = 2'b01,
    sqsh_b_first = 2'b10,
    sqsh_b_hold = 2'b11
  } sqsh_bar_state_t;
endpackage

// ==== design/sqsh_queue_mem.sv ====
// Snoop queue storage with registered read data
`timescale 1ns/1ps
module sqsh_queue_mem #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 4,
  parameter int AW = 2
) (
  // Clock and control
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // Write port
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  // Read port
  input wire logic [AW-1:0] rd_addr_in,
  output logic [WIDTH-1:0] rd_data_out
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_sys_in) begin
    if (ce_in && wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      rd_data_out <= '0;
    end else if (ce_in) begin
      rd_data_out <= mem[rd_addr_in];
    end
  end
endmodule

// ==== design/sqsh_barrier_sync.sv ====
// Outgoing memory barrier synchronization handshake
`timescale 1ns/1ps
`include "sqsh_params.svh"
module sqsh_barrier_sync (
  // Clock and control
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // Barrier execution
  input wire logic barrier_start_in,
  input wire logic barrier_full_in,
  input wire logic [1:0] barrier_ordering_field_in,
  input wire logic fetch_halted_in,
  input wire logic store_buffer_empty_in,
  input wire logic irq_pending_in,
  output logic barrier_done_out,
  output logic barrier_abort_out,
  // System handshake
  input wire logic sync_ack_in,
  output logic sync_req_out
);
  import sqsh_pkg::*;

  sqsh_bar_state_t state, next_state;
  logic needs_sync, drained, done_now, abort_now;

  assign needs_sync = barrier_full_in ||
                      (barrier_ordering_field_in <= `SQSH_ORD_SYNC_MAX);
  assign drained = fetch_halted_in && store_buffer_empty_in && !irq_pending_in && !sync_ack_in;
  assign done_now = (state == sqsh_b_idle && barrier_start_in && !needs_sync) ||
                    (state == sqsh_b_hold && sync_ack_in);
  assign abort_now = irq_pending_in && ((state == sqsh_b_first) ||
                     (state == sqsh_b_hold && !sync_ack_in));
  assign sync_req_out = (state == sqsh_b_first) || (state == sqsh_b_hold);

  always_comb begin
    next_state = state;
    case (state)
      sqsh_b_idle: begin
        if (barrier_start_in && needs_sync) begin
          next_state = sqsh_b_drain;
        end
      end
      sqsh_b_drain: begin
        if (drained) begin
          next_state = sqsh_b_first;
        end
      end
      sqsh_b_first: begin
        // Acknowledge is not looked at in the first request cycle
        next_state = irq_pending_in ? sqsh_b_drain : sqsh_b_hold;
      end
      sqsh_b_hold: begin
        if (sync_ack_in) begin
          next_state = sqsh_b_idle;
        end else if (irq_pending_in) begin
          next_state = sqsh_b_drain;
        end
      end
      default: begin
        next_state = sqsh_b_idle;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      state <= sqsh_b_idle;
      barrier_done_out <= 1'b0;
      barrier_abort_out <= 1'b0;
    end else if (ce_in) begin
      state <= next_state;
      barrier_done_out <= done_now;
      barrier_abort_out <= abort_now;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);

  req_hold_a: assert property (
    sync_req_out && !sync_ack_in && !irq_pending_in && ce_in |=> sync_req_out)
    else $error("sync request dropped early");
  ack_drop_a: assert property (
    sync_req_out && $past(sync_req_out) && sync_ack_in && ce_in |=> !sync_req_out)
    else $error("sync request held after ack");
  ord_two_a: assert property (
    state == sqsh_b_idle && barrier_start_in && !barrier_full_in &&
    barrier_ordering_field_in == `SQSH_ORD_NO_SYNC && ce_in |=>
    !sync_req_out ##1 !sync_req_out)
    else $error("sync raised for ordering two");
  bar_done_c: cover property (sync_req_out ##1 sync_req_out && sync_ack_in ##1 barrier_done_out);
endmodule

// ==== design/sqsh_top.sv ====
// Snoop queue, cache lookup sequencing and memory sync handshakes
`timescale 1ns/1ps
`include "sqsh_params.svh"
module sqsh_top #(
  parameter int DEPTH = `SQSH_QDEPTH,
  parameter int ID_W = `SQSH_ID_W,
  parameter int ADDR_W = `SQSH_ADDR_W
) (
  // Clock and control
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // Snoop request
  input wire logic snoop_req_in,
  input wire logic [`SQSH_CMD_W-1:0] snoop_cmd_in,
  input wire logic [ADDR_W-1:0] snoop_addr_in,
  input wire logic [ID_W-1:0] snoop_tag_in,
  output logic snoop_rdy_out,
  // Snoop acknowledge
  output logic snoop_ack_out,
  output logic [ID_W-1:0] snoop_tag_out,
  output logic [`SQSH_RESP_W-1:0] snoop_resp_out,
  // Data cache port
  input wire logic dcache_enable_bit_in,
  output logic dcache_enabled_out,
  output logic cache_lookup_out,
  output logic [ADDR_W-1:0] cache_lookup_addr_out,
  input wire logic cache_hit_in,
  input wire logic cache_dirty_in,
  input wire logic cache_locked_in,
  input wire logic cache_tag_perr_in,
  output logic cache_invalidate_out,
  output logic machine_check_out,
  input wire logic cpu_dcache_req_in,
  output logic cac_stalled_out,
  // Incoming sync handshake
  input wire logic stopped_in,
  input wire logic sync_req_in,
  output logic sync_ack_out,
  // Outgoing barrier sync handshake
  input wire logic barrier_start_in,
  input wire logic barrier_full_in,
  input wire logic [1:0] barrier_ordering_field_in,
  input wire logic fetch_halted_in,
  input wire logic store_buffer_empty_in,
  input wire logic irq_pending_in,
  input wire logic sync_ack_in,
  output logic sync_req_out,
  output logic barrier_done_out,
  output logic barrier_abort_out
);
  import sqsh_pkg::*;

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam int ENT_W = `SQSH_CMD_W + ID_W + ADDR_W;
  localparam int RW = `SQSH_RDY_WINDOW;

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Queue bookkeeping
  logic [PTR_W-1:0] wr_ptr, rd_ptr;
  logic [CNT_W-1:0] count, next_count, free_cnt, drain_left;
  logic [RW-1:0] rdy_hist;
  logic window_open, cmd_ok, push, pop, q_empty, q_full;
  logic [ENT_W-1:0] head;
  sqsh_cmd_t head_cmd;
  logic [ID_W-1:0] head_tag;
  logic is_inv, bypass, done_entry, perr_hit;
  logic [2:0] resp_hi;
  logic [`SQSH_RESP_W-1:0] resp_next;
  sqsh_snp_state_t state, next_state;
  logic req_eff, req_seen, capture;

  assign free_cnt = CNT_W'(DEPTH) - count;
  assign snoop_rdy_out = snoop_req_in ? (free_cnt >= CNT_W'(`SQSH_RDY_FREE_PEND)) :
                         (free_cnt >= CNT_W'(`SQSH_RDY_FREE_IDLE));
  assign window_open = |rdy_hist;
  assign cmd_ok = sqsh_cmd_t'(snoop_cmd_in) != sqsh_cmd_rsvd;
  assign q_empty = (count == '0);
  assign q_full = (count == CNT_W'(DEPTH));
  assign push = ce_in && snoop_req_in && window_open && cmd_ok && !q_full;
  assign pop = ce_in && done_entry;
  assign next_count = count + CNT_W'(push) - CNT_W'(pop);

  sqsh_queue_mem #(
    .WIDTH(ENT_W),
    .DEPTH(DEPTH),
    .AW(PTR_W)
  ) u_mem (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .wr_en_in(push),
    .wr_addr_in(wr_ptr),
    .wr_data_in({snoop_cmd_in, snoop_tag_in, snoop_addr_in}),
    .rd_addr_in(rd_ptr),
    .rd_data_out(head)
  );

  // Head entry fields
  assign head_cmd = sqsh_cmd_t'(head[ENT_W-1 -: `SQSH_CMD_W]);
  assign head_tag = head[ADDR_W +: ID_W];
  assign is_inv = (head_cmd == sqsh_invalidate_cmd);
  assign bypass = (head_cmd == sqsh_cmd_sync) || !dcache_enable_bit_in;
  assign done_entry = (state == sqsh_s_look && bypass) || (state == sqsh_s_resp);

  // Cache side
  assign dcache_enabled_out = dcache_enable_bit_in;
  assign cache_lookup_out = (state == sqsh_s_look) && !bypass;
  assign cache_lookup_addr_out = head[ADDR_W-1:0];
  assign cache_invalidate_out = ce_in && (state == sqsh_s_resp) && is_inv && cache_hit_in &&
                                !cache_tag_perr_in;
  assign cac_stalled_out = cpu_dcache_req_in &&
                           (cache_lookup_out || state == sqsh_s_resp);

  // Response coding
  assign perr_hit = cache_tag_perr_in && (is_inv || !cache_hit_in);
  assign resp_hi = perr_hit ? `SQSH_RESP_PERR :
                   cache_hit_in ? {`SQSH_RESP_HIT, cache_locked_in, cache_dirty_in} :
                   `SQSH_RESP_NULL;
  assign resp_next = (state == sqsh_s_look) ?
                     ((head_cmd == sqsh_cmd_sync) ? `SQSH_RESP_SYNC :
                      {`SQSH_RESP_NULL, `SQSH_CC_NONE}) :
                     {resp_hi, `SQSH_CC_NONE};

  always_comb begin
    next_state = state;
    case (state)
      sqsh_s_idle: begin
        // Any queued snoop starts at once; all but sync snoops and snoops with the cache disabled take the cache before the processor
        if (!q_empty) begin
          next_state = sqsh_s_look;
        end
      end
      sqsh_s_look: begin
        next_state = bypass ? sqsh_s_idle : sqsh_s_resp;
      end
      sqsh_s_resp: begin
        next_state = sqsh_s_idle;
      end
      default: begin
        next_state = sqsh_s_idle;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      state <= sqsh_s_idle;
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      rdy_hist <= '0;
    end else if (ce_in) begin
      state <= next_state;
      wr_ptr <= push ? ptr_inc(wr_ptr) : wr_ptr;
      rd_ptr <= pop ? ptr_inc(rd_ptr) : rd_ptr;
      count <= next_count;
      rdy_hist <= {rdy_hist[RW-2:0], snoop_rdy_out};
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      snoop_ack_out <= 1'b0;
      snoop_tag_out <= '0;
      snoop_resp_out <= '0;
      machine_check_out <= 1'b0;
    end else if (ce_in) begin
      snoop_ack_out <= done_entry;
      snoop_tag_out <= head_tag;
      snoop_resp_out <= resp_next;
      machine_check_out <= (state == sqsh_s_resp) && is_inv && cache_tag_perr_in;
    end
  end

  // Incoming sync: snapshot of entries ahead, counted down as they leave
  assign req_eff = sync_req_in && !stopped_in;
  assign capture = req_eff && !req_seen;

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      req_seen <= 1'b0;
      drain_left <= '0;
      sync_ack_out <= 1'b0;
    end else if (ce_in) begin
      req_seen <= req_eff;
      if (capture) begin
        drain_left <= next_count;
      end else if (pop && drain_left != '0) begin
        drain_left <= drain_left - 1'b1;
      end
      sync_ack_out <= req_eff && req_seen && (drain_left == '0);
    end
  end

  sqsh_barrier_sync u_bar (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .barrier_start_in(barrier_start_in),
    .barrier_full_in(barrier_full_in),
    .barrier_ordering_field_in(barrier_ordering_field_in),
    .fetch_halted_in(fetch_halted_in),
    .store_buffer_empty_in(store_buffer_empty_in),
    .irq_pending_in(irq_pending_in),
    .barrier_done_out(barrier_done_out),
    .barrier_abort_out(barrier_abort_out),
    .sync_ack_in(sync_ack_in),
    .sync_req_out(sync_req_out)
  );

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);

  ready_window_a: assert property (
    push |-> $past(snoop_rdy_out) || $past(snoop_rdy_out, 2))
    else $error("snoop taken outside ready window");
  rsvd_drop_a: assert property (
    snoop_req_in && snoop_cmd_in == sqsh_cmd_rsvd && !done_entry && ce_in |=> $stable(count))
    else $error("reserved command allocated an entry");
  ack_tag_a: assert property (
    snoop_ack_out |-> snoop_tag_out == $past(head_tag))
    else $error("ack tag differs from entry");
  null_keep_a: assert property (
    cache_invalidate_out |-> head_cmd == sqsh_invalidate_cmd)
    else $error("invalidate from non-invalidate snoop");
  null_quiet_a: assert property (
    state == sqsh_s_resp && head_cmd == sqsh_cmd_null && ce_in |->
    !cache_invalidate_out ##1 !machine_check_out)
    else $error("null snoop changed the cache");
  inv_hit_a: assert property (
    cache_lookup_out && is_inv && ce_in ##1 cache_hit_in && !cache_tag_perr_in |->
    cache_invalidate_out)
    else $error("hit line not invalidated");
  perr_mcheck_a: assert property (
    state == sqsh_s_resp && is_inv && cache_tag_perr_in && ce_in |=>
    machine_check_out && snoop_ack_out && snoop_resp_out[4:2] == `SQSH_RESP_PERR)
    else $error("parity error not reported");
  cc_zero_a: assert property (
    snoop_ack_out |-> snoop_resp_out[1:0] == `SQSH_CC_NONE)
    else $error("collapse count not zero");
  stall_out_a: assert property (
    cache_lookup_out && cpu_dcache_req_in |-> cac_stalled_out)
    else $error("stall not shown");
  stall_result_a: assert property (
    state == sqsh_s_resp && cpu_dcache_req_in |-> cac_stalled_out)
    else $error("stall not shown in result cycle");
  snoop_prio_a: assert property (
    state == sqsh_s_idle && !q_empty && ce_in |=> state == sqsh_s_look)
    else $error("queued snoop not started");
  disabled_lookup_a: assert property (
    !dcache_enable_bit_in |-> !cache_lookup_out && !dcache_enabled_out)
    else $error("lookup while cache disabled");
  disabled_resp_a: assert property (
    state == sqsh_s_look && !dcache_enable_bit_in && head_cmd != sqsh_cmd_sync && ce_in |=>
    snoop_ack_out && snoop_resp_out == {`SQSH_RESP_NULL, `SQSH_CC_NONE})
    else $error("disabled cache gave a non-null response");
  sync_resp_a: assert property (
    state == sqsh_s_look && head_cmd == sqsh_cmd_sync && ce_in |=>
    snoop_ack_out && snoop_resp_out == `SQSH_RESP_SYNC)
    else $error("sync response wrong");

  sync_drop_a: assert property (
    !sync_req_in && ce_in |=> !sync_ack_out)
    else $error("sync ack held after request drop");
  stop_ack_a: assert property (
    stopped_in && ce_in |=> !sync_ack_out)
    else $error("sync ack while stopped");
  drain_ack_a: assert property (
    sync_ack_out |-> drain_left == '0)
    else $error("sync ack before drain");

  snoop_sync_c: cover property (snoop_ack_out && snoop_resp_out == `SQSH_RESP_SYNC);
  snoop_inv_c: cover property (cache_invalidate_out);
  sync_in_c: cover property (capture && next_count != '0 ##[1:20] sync_ack_out);
  stall_c: cover property (cac_stalled_out);
endmodule

// ==== tb/sqsh_sys_model.sv ====
// System-side partner: data cache array responder and outgoing sync acknowledger
`timescale 1ns/1ps
module sqsh_sys_model (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic srst_in,
  // Line state and ack hold chosen by the bench
  input wire logic hit_in,
  input wire logic dirty_in,
  input wire logic locked_in,
  input wire logic perr_in,
  input wire logic hold_ack_in,
  // Core side
  input wire logic cache_lookup_in,
  input wire logic sync_req_in,
  output logic cache_hit_out,
  output logic cache_dirty_out,
  output logic cache_locked_out,
  output logic cache_tag_perr_out,
  output logic sync_ack_out
);
  logic result_cycle;
  logic noise;
  logic ack;
  // Results are valid only the cycle after a lookup; otherwise the lines toggle
  always_ff @(posedge clk_sys_in) begin
    result_cycle <= cache_lookup_in & !srst_in;
    noise <= !srst_in & !noise;
    ack <= !srst_in & sync_req_in & !hold_ack_in;
  end
  assign cache_hit_out = result_cycle ? hit_in : noise;
  assign cache_dirty_out = result_cycle ? dirty_in : !noise;
  assign cache_locked_out = result_cycle ? locked_in : noise;
  assign cache_tag_perr_out = result_cycle ? perr_in : !noise;
  assign sync_ack_out = ack;
endmodule

// ==== tb/test_snoop_queue_and_sync_handshake.sv ====
// Self-checking bench for the snoop queue and synchronization handshakes
`timescale 1ns/1ps
module test_snoop_queue_and_sync_handshake;
  import sqsh_pkg::*;
  logic clk_sys_in = 1'b0;
  logic srst_in = 1'b1;
  logic ce_in = 1'b1;
  logic snoop_req_in = 1'b0;
  logic [1:0] snoop_cmd_in = 2'h0;
  logic [26:0] snoop_addr_in = 27'h0;
  logic [3:0] snoop_tag_in = 4'h0;
  logic dcache_enable_bit_in = 1'b1;
  logic cpu_dcache_req_in = 1'b1;
  logic stopped_in = 1'b0;
  logic sync_req_in = 1'b0;
  logic barrier_start_in = 1'b0;
  logic barrier_full_in = 1'b0;
  logic [1:0] barrier_ordering_field_in = 2'h0;
  logic fetch_halted_in = 1'b1;
  logic store_buffer_empty_in = 1'b1;
  logic irq_pending_in = 1'b0;
  logic [3:0] line_state = 4'h0;
  logic hold_ack = 1'b0;
  logic snoop_rdy_out, snoop_ack_out, dcache_enabled_out, cache_lookup_out;
  logic [3:0] snoop_tag_out;
  logic [4:0] snoop_resp_out;
  logic [26:0] cache_lookup_addr_out, seen_addr;
  logic cache_hit_in, cache_dirty_in, cache_locked_in, cache_tag_perr_in;
  logic cache_invalidate_out, machine_check_out, cac_stalled_out, sync_ack_out;
  logic sync_ack_in, sync_req_out, barrier_done_out, barrier_abort_out;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  int ack_cnt = 0, inv_cnt = 0, mc_cnt = 0, stall_cnt = 0, look_cnt = 0, sack_cnt = 0;
  int sreq_cnt = 0;

  sqsh_top i_sqsh_top (.clk_sys_in, .srst_in, .ce_in, .snoop_req_in, .snoop_cmd_in,
    .snoop_addr_in, .snoop_tag_in, .snoop_rdy_out, .snoop_ack_out, .snoop_tag_out,
    .snoop_resp_out, .dcache_enable_bit_in, .dcache_enabled_out, .cache_lookup_out,
    .cache_lookup_addr_out, .cache_hit_in, .cache_dirty_in, .cache_locked_in,
    .cache_tag_perr_in, .cache_invalidate_out, .machine_check_out, .cpu_dcache_req_in,
    .cac_stalled_out, .stopped_in, .sync_req_in, .sync_ack_out, .barrier_start_in,
    .barrier_full_in, .barrier_ordering_field_in, .fetch_halted_in, .store_buffer_empty_in,
    .irq_pending_in, .sync_ack_in, .sync_req_out, .barrier_done_out, .barrier_abort_out);

  sqsh_sys_model i_sqsh_sys_model (.clk_sys_in, .srst_in, .hit_in(line_state[3]),
    .dirty_in(line_state[2]), .locked_in(line_state[1]), .perr_in(line_state[0]),
    .hold_ack_in(hold_ack), .cache_lookup_in(cache_lookup_out), .sync_req_in(sync_req_out),
    .cache_hit_out(cache_hit_in), .cache_dirty_out(cache_dirty_in),
    .cache_locked_out(cache_locked_in), .cache_tag_perr_out(cache_tag_perr_in),
    .sync_ack_out(sync_ack_in));

  always #10 clk_sys_in = ~clk_sys_in;

  // Event counters sampled on every rising edge
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    ack_cnt <= ack_cnt + int'(snoop_ack_out === 1'b1);
    inv_cnt <= inv_cnt + int'(cache_invalidate_out === 1'b1);
    mc_cnt <= mc_cnt + int'(machine_check_out === 1'b1);
    stall_cnt <= stall_cnt + int'(cac_stalled_out === 1'b1);
    look_cnt <= look_cnt + int'(cache_lookup_out === 1'b1);
    if (cache_lookup_out === 1'b1) seen_addr <= cache_lookup_addr_out;
    if ($rose(sync_ack_out)) sack_cnt <= sack_cnt + 1;
    if ($rose(sync_req_out)) sreq_cnt <= sreq_cnt + 1;
  end

  task automatic print_verdict();
    if (miscompares == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys_in) begin
    if (cycles == 3000) begin
      miscompares = miscompares + 1;
      print_verdict();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_for(ref logic sig, input int lim);
    int n;
    n = 0;
    #1;
    while (sig !== 1'b1 && n < lim) begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
  endtask

  task automatic run_case(input logic [1:0] cmd, input logic [3:0] st, input logic en,
                          input logic [4:0] exp, input int invalidate_cmd, input int mc, input int lk);
    int i0, m0, s0, l0;
    logic [3:0] tag;
    i0 = inv_cnt;
    m0 = mc_cnt;
    s0 = stall_cnt;
    l0 = look_cnt;
    tag = snoop_tag_in + 4'h7;
    @(posedge clk_sys_in);
    chk("snoop_rdy", 1, snoop_rdy_out);
    line_state <= st;
    dcache_enable_bit_in <= en;
    snoop_req_in <= 1'b1;
    snoop_cmd_in <= cmd;
    snoop_tag_in <= tag;
    snoop_addr_in <= {tag, 23'h2b3c5d};
    @(posedge clk_sys_in);
    snoop_req_in <= 1'b0;
    wait_for(snoop_ack_out, 12);
    chk("snoop_ack", 1, snoop_ack_out);
    chk("snoop_tag", tag, snoop_tag_out);
    chk("snoop_resp", exp, snoop_resp_out);
    chk("dcache_enabled", en, dcache_enabled_out);
    repeat (2) @(posedge clk_sys_in);
    #1;
    chk("invalidates", invalidate_cmd, inv_cnt - i0);
    chk("machine_checks", mc, mc_cnt - m0);
    chk("lookups", lk, look_cnt - l0);
    chk("stall_cycles", 2 * lk, stall_cnt - s0);
    if (lk != 0) chk("lookup_addr", snoop_addr_in, seen_addr);
  endtask

  task automatic reserved_cmd();
    int a0;
    a0 = ack_cnt;
    @(posedge clk_sys_in);
    snoop_req_in <= 1'b1;
    snoop_cmd_in <= 2'h3;
    @(posedge clk_sys_in);
    snoop_req_in <= 1'b0;
    repeat (10) @(posedge clk_sys_in);
    #1;
    chk("reserved_acks", 0, ack_cnt - a0);
  endtask

  task automatic sync_in_drain();
    int a0;
    a0 = ack_cnt;
    @(posedge clk_sys_in);
    line_state <= 4'h8;
    snoop_req_in <= 1'b1;
    snoop_cmd_in <= 2'h1;
    @(posedge clk_sys_in);
    snoop_cmd_in <= 2'h0;
    sync_req_in <= 1'b1;
    @(posedge clk_sys_in);
    snoop_req_in <= 1'b0;
    wait_for(sync_ack_out, 20);
    chk("acks_at_sync_ack", 2, ack_cnt - a0 + int'(snoop_ack_out === 1'b1));
    @(posedge clk_sys_in);
    sync_req_in <= 1'b0;
    #1;
    chk("sync_ack_hold", 1, sync_ack_out);
    @(posedge clk_sys_in);
    #1;
    chk("sync_ack_drop", 0, sync_ack_out);
  endtask

  task automatic sync_in_refused();
    int s0;
    s0 = sack_cnt;
    @(posedge clk_sys_in);
    sync_req_in <= 1'b1;
    @(posedge clk_sys_in);
    sync_req_in <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
    stopped_in <= 1'b1;
    @(posedge clk_sys_in);
    sync_req_in <= 1'b1;
    repeat (8) @(posedge clk_sys_in);
    #1;
    chk("sync_acks", 0, sack_cnt - s0);
    @(posedge clk_sys_in);
    stopped_in <= 1'b0;
    wait_for(sync_ack_out, 8);
    chk("sync_ack_after_stop", 1, sync_ack_out);
    @(posedge clk_sys_in);
    sync_req_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
  endtask

  task automatic barrier(input logic full, input logic [1:0] ord, input int exp_req);
    int r0;
    r0 = sreq_cnt;
    @(posedge clk_sys_in);
    barrier_start_in <= 1'b1;
    barrier_full_in <= full;
    barrier_ordering_field_in <= ord;
    @(posedge clk_sys_in);
    barrier_start_in <= 1'b0;
    wait_for(barrier_done_out, 12);
    chk("barrier_done", 1, barrier_done_out);
    @(posedge clk_sys_in);
    #1;
    chk("sync_requests", exp_req, sreq_cnt - r0);
    chk("sync_req_low", 0, sync_req_out);
  endtask

  task automatic barrier_abort();
    int r0;
    r0 = sreq_cnt;
    @(posedge clk_sys_in);
    hold_ack <= 1'b1;
    store_buffer_empty_in <= 1'b0;
    barrier_start_in <= 1'b1;
    barrier_full_in <= 1'b1;
    @(posedge clk_sys_in);
    barrier_start_in <= 1'b0;
    repeat (5) @(posedge clk_sys_in);
    #1;
    chk("req_before_drain", 0, sreq_cnt - r0);
    @(posedge clk_sys_in);
    store_buffer_empty_in <= 1'b1;
    wait_for(sync_req_out, 8);
    @(posedge clk_sys_in);
    irq_pending_in <= 1'b1;
    wait_for(barrier_abort_out, 8);
    chk("abort", 1, barrier_abort_out);
    @(posedge clk_sys_in);
    #1;
    chk("req_after_abort", 0, sync_req_out);
    @(posedge clk_sys_in);
    irq_pending_in <= 1'b0;
    hold_ack <= 1'b0;
    wait_for(barrier_done_out, 16);
    chk("retry_done", 1, barrier_done_out);
    chk("retry_requests", 2, sreq_cnt - r0);
  endtask

  initial begin
    repeat (2) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    run_case(2'h0, 4'b1000, 1'b1, 5'h10, 0, 0, 1);
    run_case(2'h1, 4'b1110, 1'b1, 5'h1c, 1, 0, 1);
    run_case(2'h1, 4'b1100, 1'b1, 5'h14, 1, 0, 1);
    run_case(2'h0, 4'b1010, 1'b1, 5'h18, 0, 0, 1);
    run_case(2'h0, 4'b0000, 1'b1, 5'h00, 0, 0, 1);
    run_case(2'h0, 4'b0001, 1'b1, 5'h08, 0, 0, 1);
    run_case(2'h1, 4'b1111, 1'b1, 5'h08, 0, 1, 1);
    run_case(2'h2, 4'b1000, 1'b1, 5'h0c, 0, 0, 0);
    run_case(2'h1, 4'b1000, 1'b0, 5'h00, 0, 0, 0);
    dcache_enable_bit_in <= 1'b1;
    reserved_cmd();
    sync_in_drain();
    sync_in_refused();
    barrier(1'b1, 2'h2, 1);
    barrier(1'b0, 2'h0, 1);
    barrier(1'b0, 2'h1, 1);
    barrier(1'b0, 2'h2, 0);
    barrier(1'b0, 2'h3, 0);
    barrier_abort();
    print_verdict();
  end
endmodule
